// >>> soac_pkg.sv
package soac_pkg;

  // Structure sizes.
  localparam int N_SRC     = 3;
  localparam int N_VC      = 2;
  localparam int N_CLS     = 3;
  localparam int SRC_LOCAL = 2;
  localparam int PHASES    = 128;
  localparam int CRED_W    = 8;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_TCMAP  = 8'h04;
  localparam logic [7:0] OFF_PHASE  = 8'h08;
  localparam logic [7:0] OFF_VCW    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions.
  localparam int CTRL_PARB_LSB = 0;
  localparam int CTRL_VARB_LSB = 2;
  localparam int CTRL_ACS_LSB  = 4;
  localparam int PHASE_VC_BIT  = 8;
  localparam int PHASE_SRC_LSB = 16;
  localparam int VCW_W1_LSB    = 4;
  localparam int STAT_CNT_LSB  = 16;

  // Reset values.
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] TCMAP_RST = 8'h00;
  localparam logic [7:0] VCW_RST   = 8'h11;

  // Timing.
  localparam int CLK_MHZ        = 100;
  localparam int FC_REFRESH_US  = 30;
  localparam int FC_REFRESH_CYC = FC_REFRESH_US * CLK_MHZ;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PARB_RR, PARB_WRR, PARB_TWRR} soac_parb_type;
  typedef enum logic [1:0] {VARB_STRICT, VARB_RR, VARB_WRR} soac_varb_type;
  typedef enum logic [1:0] {CL_POSTED, CL_NONPOSTED, CL_CPL} soac_class_type;

  // Head-of-queue descriptor offered by one ingress queue.
  typedef struct packed {
    logic       valid;
    logic       ro;
    logic       wcpl;
    logic       p2p;
    logic       acs_ok;
    logic [2:0] tc;
    logic [7:0] seq;
  } soac_head_type;

  // Descriptor handed to the transmit stage.
  typedef struct packed {
    logic [1:0]     src;
    logic           vc;
    soac_class_type cls;
    logic [2:0]     tc;
    logic           ro;
    logic           redirect;
    logic [7:0]     seq;
  } soac_tx_type;

endpackage

// >>> soac_port_arb.sv
`timescale 1ns/1ps
module soac_port_arb
  import soac_pkg::*;
(
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               reset_n,
  // Requests and mode.
  input  wire logic [N_SRC-1:0]   req,
  input  wire soac_parb_type      mode,
  // Phase table write.
  input  wire logic               tbl_we,
  input  wire logic [6:0]         tbl_idx,
  input  wire logic [1:0]         tbl_src,
  // Grant.
  input  wire logic               take,
  output logic                    gnt_any,
  output logic [1:0]              gnt_src
);

  logic [1:0] table_r [PHASES];
  logic [6:0] phase_r;
  logic [1:0] last_r;

  // Round robin search order starting after the last winner.
  wire [1:0] c1 = (last_r == 2'(N_SRC - 1)) ? 2'h0 : 2'(last_r + 2'h1);
  wire [1:0] c2 = (c1 == 2'(N_SRC - 1)) ? 2'h0 : 2'(c1 + 2'h1);
  wire [1:0] rr_src = req[c1] ? c1 : (req[c2] ? c2 : last_r);
  wire       rr_any = |req;
  wire [1:0] slot = table_r[phase_r];
  wire       slot_hit = (slot < 2'(N_SRC)) && req[slot];

  // Scheme selection; unknown codes fall back to round robin.
  always_comb begin
    case (mode)
      PARB_WRR: begin
        gnt_any = rr_any; // RULE8
        gnt_src = slot_hit ? slot : rr_src;
      end
      PARB_TWRR: begin
        gnt_any = slot_hit; // RULE8
        gnt_src = slot;
      end
      default: begin
        gnt_any = rr_any;
        gnt_src = rr_src;
      end
    endcase
  end

  // Phase table resets to a plain rotation over the sources.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PHASES; i++) begin
        table_r[i] <= 2'(i % N_SRC); // RULE21
      end
    end else if (tbl_we) begin
      table_r[tbl_idx] <= tbl_src;
    end
  end

  // Phase advances per grant in weighted mode, per slot in timed mode.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 7'h00;
      last_r  <= 2'(N_SRC - 1);
    end else begin
      if (take) begin
        last_r <= gnt_src;
      end
      if ((mode == PARB_TWRR) || (take && mode == PARB_WRR)) begin
        phase_r <= 7'(phase_r + 7'h01);
      end
    end
  end

  AST_TWRR_SLOT: assert property (@(posedge clock) disable iff (!reset_n) // RULE8
    (mode == PARB_TWRR) |=> (phase_r == 7'($past(phase_r) + 7'h01)))
    else $error("Timed arbitration phase did not advance every cycle.");

endmodule // soac_port_arb

// >>> soac_sched.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// [RULE1] Ordering checks compare only packets of the same traffic class.
// [RULE2] Channel 0 and channel 1 queues never block each other.
// [RULE3] Posted requests leave each queue in arrival order.
// [RULE4] Non-posted requests wait behind older posted requests.
// [RULE5] Completions without relaxed ordering wait behind older posted data.
// [RULE6] Write completions may pass older posted requests.
// [RULE7] Posted may pass others; a fairness toggle shares posted and rest.
// [RULE8] Port arbiter offers round robin, weighted and timed 128-phase.
// [RULE9] Two independent port arbiters, one per virtual channel.
// [RULE10] Local completions compete only in channel 0 arbitration.
// [RULE11] Channel arbitration is strict, round robin or weighted.
// [RULE12] Nothing is sent without partner credit for it.
// [RULE13] Freed receive credits per class are reported once they change.
// [RULE14] Credit report repeats every 30 us when nothing changed.
// [RULE15] Partner credits are captured and gate all sources.
// [RULE16] Transmit stage takes packets from the channel arbiter output.
// [RULE17] With access control on, peer packets follow its verdict.
// [RULE18] Class to channel map resets with every class on channel 0.
// [RULE19] Non-posted requests only use channel 0.
// [RULE20] Low channel-1 enable folds all traffic onto channel 0.
// [RULE21] Permitted passing keeps arrival order; weights reset to even.
module soac_sched
  import soac_pkg::*;
(
  // Clock and reset.
  input  wire logic                                  clock,
  input  wire logic                                  reset_n,
  // AXI4-Lite register slave.
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [7:0]                            s_axi_awaddr,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  output logic [1:0]                                 s_axi_bresp,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  input  wire logic [7:0]                            s_axi_araddr,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  // Ingress queue heads.
  input  wire soac_head_type [N_SRC-1:0][N_VC-1:0]   p_head,
  input  wire soac_head_type [N_SRC-1:0]             np_head,
  input  wire soac_head_type [N_SRC-1:0][N_VC-1:0]   c_head,
  // Partner credit advertisement from the link layer.
  input  wire logic                                  link_cred_valid,
  input  wire logic [N_VC-1:0][N_CLS-1:0][CRED_W-1:0] link_cred,
  // Transmit stage.
  output logic                                       tx_valid,
  input  wire logic                                  tx_ready,
  output soac_tx_type                                tx_desc,
  output logic                                       tx_pop,
  // Receive credit reporting.
  input  wire logic [N_VC-1:0][N_CLS-1:0]            rx_free,
  output logic                                       fc_valid,
  output logic [N_VC-1:0][N_CLS-1:0][CRED_W-1:0]     fc_credits,
  // Receive class mapping.
  input  wire logic [2:0]                            rx_tc,
  input  wire logic                                  rx_np,
  output logic                                       rx_vc,
  // Pin.
  input  wire logic                                  second_channel_enable
);

  logic [7:0]  ctrl_r;
  logic [7:0]  tcmap_r;
  logic [7:0]  vcw_r;
  logic [15:0] tx_cnt_r;
  logic        vc1_meta_r;
  logic        second_channel_enable_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [N_VC-1:0][N_CLS-1:0][CRED_W-1:0] lim_r, used_r, rx_cnt_r, rep_r;
  logic [N_VC-1:0][N_CLS-1:0]             cred_ok;
  logic [N_SRC-1:0][N_VC-1:0]             fair_r;
  logic [N_VC-1:0][N_SRC-1:0]             req;
  soac_class_type                         cls_sel [N_SRC][N_VC];
  logic [N_VC-1:0]                        pa_any;
  logic [1:0]                             pa_src [N_VC];
  logic        vlast_r, vcur_r;
  logic [3:0]  vcnt_r;
  logic        vsel;
  logic        tx_valid_r, tx_pop_r;
  soac_tx_type tx_desc_r;
  logic [11:0] fc_timer_r;
  logic        fc_valid_r;
  logic        rx_vc_r;

  // True when stamp a was taken before stamp b.
  function automatic logic older(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = 8'(b - a);
    return (d != 8'h00) && !d[7];
  endfunction

  // Channel-1 enable pin synchroniser.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vc1_meta_r <= 1'b0;
      second_channel_enable_r   <= 1'b0;
    end else begin
      vc1_meta_r <= second_channel_enable;
      second_channel_enable_r   <= vc1_meta_r;
    end
  end

  // Register decode.
  wire soac_parb_type parb = soac_parb_type'(ctrl_r[CTRL_PARB_LSB +: 2]);
  wire soac_varb_type varb = soac_varb_type'(ctrl_r[CTRL_VARB_LSB +: 2]);
  wire [2:0] acs_en = ctrl_r[CTRL_ACS_LSB +: 3];
  wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_ctrl  = awaddr_r == OFF_CTRL;
  wire wr_tcmap = awaddr_r == OFF_TCMAP;
  wire wr_phase = awaddr_r == OFF_PHASE;
  wire wr_vcw   = awaddr_r == OFF_VCW;
  wire wr_hit   = wr_ctrl | wr_tcmap | wr_phase | wr_vcw;
  wire tbl_we   = do_write & wr_phase & wstrb0_r;
  wire phase_vc = wdata_r[PHASE_VC_BIT];
  wire rd_hit   = (s_axi_araddr == OFF_CTRL) | (s_axi_araddr == OFF_TCMAP)
                | (s_axi_araddr == OFF_VCW) | (s_axi_araddr == OFF_STATUS)
                | (s_axi_araddr == OFF_PHASE);
  wire [31:0] rd_mux =
      (s_axi_araddr == OFF_CTRL)   ? {24'h000000, ctrl_r} :
      (s_axi_araddr == OFF_TCMAP)  ? {24'h000000, tcmap_r} :
      (s_axi_araddr == OFF_VCW)    ? {24'h000000, vcw_r} :
      (s_axi_araddr == OFF_STATUS) ? {tx_cnt_r, 14'h0000, tx_valid_r,
                                      second_channel_enable_r} : 32'h00000000;

  // AXI4-Lite write channel; address and data may come in either order.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Software registers; the class map resets with all classes on channel 0.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r  <= CTRL_RST;
      tcmap_r <= TCMAP_RST; // RULE18
      vcw_r   <= VCW_RST; // RULE21
    end else if (do_write && wstrb0_r) begin
      if (wr_ctrl) ctrl_r <= wdata_r[7:0];
      if (wr_tcmap) tcmap_r <= wdata_r[7:0];
      if (wr_vcw) vcw_r <= wdata_r[7:0];
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Credit headroom per channel and class.
  for (genvar gv = 0; gv < N_VC; gv++) begin : g_cred
    for (genvar gc = 0; gc < N_CLS; gc++) begin : g_cls
      assign cred_ok[gv][gc] = (lim_r[gv][gc] != used_r[gv][gc]); // RULE12
    end
  end

  // Per-queue eligibility and class choice.
  for (genvar gs = 0; gs < N_SRC; gs++) begin : g_src
    for (genvar gv = 0; gv < N_VC; gv++) begin : g_vc
      soac_head_type ph, ch, nh;
      logic p_ok, np_blk, np_ok, c_blk, c_ok, o_ok, lane_on;
      assign ph = p_head[gs][gv];
      assign ch = c_head[gs][gv];
      assign nh = (gv == 0) ? np_head[gs] : '0; // RULE19
      assign p_ok = ph.valid & cred_ok[gv][CL_POSTED]; // RULE3 RULE7
      assign np_blk = ph.valid & (ph.tc == nh.tc) // RULE1
                    & older(ph.seq, nh.seq); // RULE4
      assign np_ok = nh.valid & ~np_blk & cred_ok[gv][CL_NONPOSTED];
      assign c_blk = ph.valid & (ph.tc == ch.tc) & older(ph.seq, ch.seq)
                   & ~ch.ro & ~ch.wcpl; // RULE5 RULE6
      assign c_ok = ch.valid & ~c_blk & cred_ok[gv][CL_CPL];
      assign o_ok = np_ok | c_ok;
      assign cls_sel[gs][gv] = (p_ok & (~fair_r[gs][gv] | ~o_ok)) ? CL_POSTED
                             : (np_ok ? CL_NONPOSTED : CL_CPL); // RULE7
      assign lane_on = (gv == 0) | (second_channel_enable_r & (gs != SRC_LOCAL)); // RULE10 RULE20
      assign req[gv][gs] = (p_ok | o_ok) & lane_on; // RULE2
    end
  end

  // Channel arbitration and grant.
  wire fire = ~tx_valid_r & (|pa_any);
  wire [3:0] w_cur = vcur_r ? vcw_r[VCW_W1_LSB +: 4] : vcw_r[3:0];
  always_comb begin
    case (varb)
      VARB_RR:  vsel = (&pa_any) ? ~vlast_r : pa_any[1]; // RULE11
      VARB_WRR: vsel = (&pa_any) ? vcur_r : pa_any[1]; // RULE11
      default:  vsel = pa_any[1]; // RULE11
    endcase
  end
  wire [1:0] sel_src = pa_src[vsel];
  wire soac_class_type sel_cls = cls_sel[sel_src][vsel];
  wire soac_head_type sel_head =
      (sel_cls == CL_POSTED)    ? p_head[sel_src][vsel] :
      (sel_cls == CL_NONPOSTED) ? np_head[sel_src] : c_head[sel_src][vsel];
  wire redirect = acs_en[sel_src] & sel_head.p2p & ~sel_head.acs_ok;

  // One port arbiter per channel.
  for (genvar gv = 0; gv < N_VC; gv++) begin : g_parb
    soac_port_arb u_arb (
      .clock   (clock),
      .reset_n (reset_n),
      .req     (req[gv]),
      .mode    (parb),
      .tbl_we  (tbl_we & (phase_vc == 1'(gv))),
      .tbl_idx (wdata_r[6:0]),
      .tbl_src (wdata_r[PHASE_SRC_LSB +: 2]),
      .take    (fire & (vsel == 1'(gv))),
      .gnt_any (pa_any[gv]),
      .gnt_src (pa_src[gv])
    ); // RULE9
  end

  // Channel arbiter history.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vlast_r <= 1'b1;
      vcur_r  <= 1'b0;
      vcnt_r  <= 4'h0;
    end else if (fire) begin
      vlast_r <= vsel;
      if (vsel == vcur_r) begin
        if (4'(vcnt_r + 4'h1) >= w_cur) begin
          vcur_r <= ~vcur_r;
          vcnt_r <= 4'h0;
        end else begin
          vcnt_r <= 4'(vcnt_r + 4'h1);
        end
      end
    end
  end

  // Transmit slot: one packet at a time, popped from its queue on grant.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid_r <= 1'b0;
      tx_pop_r   <= 1'b0;
      tx_desc_r  <= '0;
      tx_cnt_r   <= 16'h0000;
      fair_r     <= '0;
    end else begin
      tx_pop_r <= fire;
      if (fire) begin
        tx_valid_r <= 1'b1; // RULE16
        tx_desc_r  <= '{src: sel_src, vc: vsel, cls: sel_cls,
                        tc: sel_head.tc, ro: sel_head.ro,
                        redirect: redirect, seq: sel_head.seq}; // RULE17
        fair_r[sel_src][vsel] <= (sel_cls == CL_POSTED); // RULE7
      end else if (tx_valid_r && tx_ready) begin
        tx_valid_r <= 1'b0;
        tx_cnt_r   <= 16'(tx_cnt_r + 16'h0001);
      end
    end
  end

  // Partner credit capture and consumption.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lim_r  <= '0;
      used_r <= '0;
    end else begin
      if (link_cred_valid) begin
        lim_r <= link_cred; // RULE15
      end
      if (fire) begin
        used_r[vsel][sel_cls] <= 8'(used_r[vsel][sel_cls] + 8'h01); // RULE12
      end
    end
  end

  // Receive credit counting and reporting.
  wire fc_changed = (rx_cnt_r != rep_r);
  wire fc_due = (fc_timer_r == 12'(FC_REFRESH_CYC - 1));
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt_r   <= '0;
      rep_r      <= '0;
      fc_timer_r <= 12'h000;
      fc_valid_r <= 1'b0;
    end else begin
      for (int v = 0; v < N_VC; v++) begin
        for (int c = 0; c < N_CLS; c++) begin
          if (rx_free[v][c]) begin
            rx_cnt_r[v][c] <= 8'(rx_cnt_r[v][c] + 8'h01); // RULE13
          end
        end
      end
      fc_valid_r <= fc_changed | fc_due; // RULE13 RULE14
      if (fc_changed || fc_due) begin
        rep_r      <= rx_cnt_r;
        fc_timer_r <= 12'h000;
      end else begin
        fc_timer_r <= 12'(fc_timer_r + 12'h001);
      end
    end
  end

  // Receive class-to-channel mapping.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_vc_r <= 1'b0;
    end else begin
      rx_vc_r <= second_channel_enable_r & ~rx_np & tcmap_r[rx_tc]; // RULE18 RULE19 RULE20
    end
  end

  // Outputs.
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign tx_valid      = tx_valid_r;
  assign tx_desc       = tx_desc_r;
  assign tx_pop        = tx_pop_r;
  assign fc_valid      = fc_valid_r;
  assign fc_credits    = rep_r;
  assign rx_vc         = rx_vc_r;

  AST_NP_BEHIND_P: assert property (@(posedge clock) disable iff (!reset_n) // RULE4
    (fire && sel_cls == CL_NONPOSTED) |-> !(p_head[sel_src][0].valid &&
      p_head[sel_src][0].tc == sel_head.tc &&
      older(p_head[sel_src][0].seq, sel_head.seq)))
    else $error("Non-posted request passed an older posted request.");
  AST_CPL_BEHIND_P: assert property (@(posedge clock) disable iff (!reset_n) // RULE5
    (fire && sel_cls == CL_CPL && !sel_head.ro && !sel_head.wcpl) |->
      !(p_head[sel_src][vsel].valid &&
        p_head[sel_src][vsel].tc == sel_head.tc &&
        older(p_head[sel_src][vsel].seq, sel_head.seq)))
    else $error("Ordered completion passed older posted data.");
  AST_CREDIT_GATE: assert property (@(posedge clock) disable iff (!reset_n) // RULE12
    fire |-> (lim_r[vsel][sel_cls] != used_r[vsel][sel_cls]))
    else $error("Packet granted without partner credit.");
  AST_NP_ON_VC0: assert property (@(posedge clock) disable iff (!reset_n) // RULE19
    tx_pop_r && tx_desc_r.cls == CL_NONPOSTED |-> !tx_desc_r.vc)
    else $error("Non-posted request sent on channel 1.");
  AST_VC1_OFF: assert property (@(posedge clock) disable iff (!reset_n) // RULE20
    (!second_channel_enable_r && fire) |-> !vsel ##1 !rx_vc_r)
    else $error("Channel 1 used while disabled.");
  AST_LOCAL_VC0: assert property (@(posedge clock) disable iff (!reset_n) // RULE10
    (tx_pop_r && tx_desc_r.src == 2'(SRC_LOCAL)) |-> !tx_desc_r.vc)
    else $error("Local packet arbitrated on channel 1.");
  AST_STRICT: assert property (@(posedge clock) disable iff (!reset_n) // RULE11
    (fire && varb == VARB_STRICT && pa_any[1]) |=> (tx_desc_r.vc))
    else $error("Strict priority did not favour channel 1.");
  AST_FC_REFRESH: assert property (@(posedge clock) disable iff (!reset_n) // RULE14
    (fc_timer_r == 12'(FC_REFRESH_CYC - 1)) |=> fc_valid_r && fc_timer_r == 0)
    else $error("Credit refresh not sent on time.");
  AST_TX_HOLD: assert property (@(posedge clock) disable iff (!reset_n) // RULE16
    (tx_valid_r && !tx_ready) |=> tx_valid_r && $stable(tx_desc_r) && !tx_pop_r)
    else $error("Transmit descriptor changed while stalled.");

endmodule // soac_sched

// >>> soac_link_peer.sv
`timescale 1ns/1ps
// Link partner: sends credit limits on request, accepts with random stalls.
module soac_link_peer
  import soac_pkg::*;
(
  // Clock and reset.
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // Bench control.
  input  wire logic                      adv,
  input  wire logic [CRED_W-1:0]         lim,
  input  wire logic                      slow,
  // Link side.
  output logic                           link_cred_valid,
  output logic [N_VC-1:0][N_CLS-1:0][CRED_W-1:0] link_cred,
  output logic                           tx_ready
);
  int seed = 5;
  // Credit data is only meaningful with its pulse; it toggles otherwise.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_cred_valid <= 1'b0;
      link_cred       <= '0;
      tx_ready        <= 1'b0;
    end else begin
      link_cred_valid <= adv;
      link_cred <= adv ? {N_VC * N_CLS{lim}} : ~link_cred;
      tx_ready <= !slow || (($random(seed) & 1) != 0);
    end
  end
endmodule // soac_link_peer

// >>> test_switch_ordering_arbitration_credit.sv
`timescale 1ns/1ps
module test_switch_ordering_arbitration_credit
  import soac_pkg::*;
;
  // Bench state and design connections.
  int seed = 37978, num_errors = 0, checked = 0, n, i;
  logic clock, reset_n, adv, slow, link_cred_valid, tx_valid, tx_ready, tx_pop;
  logic fc_valid, rx_np, rx_vc, second_channel_enable;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, lim, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  rx_tc, t;
  soac_head_type [N_SRC-1:0][N_VC-1:0] p_head, c_head;
  soac_head_type [N_SRC-1:0]           np_head;
  logic [N_VC-1:0][N_CLS-1:0][CRED_W-1:0] link_cred, fc_credits;
  logic [N_VC-1:0][N_CLS-1:0]          rx_free;
  soac_tx_type                         tx_desc;

  soac_sched dut (.clock, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .p_head, .np_head, .c_head, .link_cred_valid,
    .link_cred, .tx_valid, .tx_ready, .tx_desc, .tx_pop, .rx_free, .fc_valid,
    .fc_credits, .rx_tc, .rx_np, .rx_vc, .second_channel_enable);
  soac_link_peer peer (.clock, .reset_n, .adv, .lim, .slow, .link_cred_valid,
    .link_cred, .tx_ready);

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task end_sim;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e, input string w);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", w, e, s);
    end
  endtask

  // One AXI4-Lite write (w=1) or read, held until its answer is taken.
  task ax(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] rd, output logic [1:0] rs);
    int k;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (k == 40) begin num_errors++; end_sim(); end
  endtask

  // Waits for a grant pulse (f=0) or a credit report (f=1).
  task wt(input logic f, input int m);
    for (n = 0; n < m; n++) begin
      @(posedge clock);
      if ((f ? fc_valid : tx_pop) === 1'b1) break;
    end
    if (n == m) begin num_errors++; end_sim(); end
  endtask

  task cnt(input int m);
    n = 0;
    repeat (m) begin
      @(posedge clock);
      n += tx_pop;
    end
  endtask

  task vc(input logic [2:0] c, input logic p, input logic e);
    rx_tc <= c;
    rx_np <= p;
    repeat (2) @(posedge clock);
    chk(rx_vc, e, "rx_vc");
  endtask

  // Main sequence.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata, p_head, np_head, c_head,
     rx_free, rx_tc, rx_np, adv, lim, slow, reset_n} = '0;
    s_axi_wstrb = 4'hF;
    second_channel_enable = 1'b1;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      ax(0, 8'(4 * i), 0, q, r);
      chk(q, i == 3 ? 32'(VCW_RST) : 32'(i == 4), "rdata");
      chk(r, i == 5 ? RESP_SLVERR : RESP_OKAY, "rresp");
    end
    ax(1, 8'h14, 0, q, r);
    chk(r, RESP_SLVERR, "bresp");
    vc(0, 0, 0);
    for (i = 0; i < 3; i++) begin
      ax(1, OFF_CTRL, 32'h20 | i << 2 | i, q, r);
      ax(0, OFF_CTRL, 0, q, r);
      chk(q, 32'h20 | i << 2 | i, "ctrl");
    end
    t = 3'($random(seed));
    ax(1, OFF_TCMAP, 32'h1 << t, q, r);
    vc(t, 0, 1);
    vc(t + 3'h1, 0, 0);
    vc(t, 1, 0);
    second_channel_enable <= 1'b0;
    repeat (3) @(posedge clock);
    vc(t, 0, 0);
    p_head[0][0].valid <= 1'b1;
    slow <= 1'b1;
    cnt(20);
    chk(n, 0, "early");
    lim <= 8'h02;
    adv <= 1'b1;
    @(posedge clock);
    adv <= 1'b0;
    cnt(80);
    chk(n, 2, "grants");
    b = 8'($random(seed));
    lim <= 8'h28;
    adv <= 1'b1;
    p_head <= '0;
    p_head[1][0] <= {5'b10010, 3'h0, b};
    np_head[1] <= {5'b10000, 3'h0, b + 8'h2};
    c_head[1][0] <= {5'b10000, 3'h0, b + 8'h3};
    @(posedge clock);
    adv <= 1'b0;
    wt(0, 300);
    chk(tx_desc.cls, CL_POSTED, "class");
    chk(tx_desc.redirect, 1, "redirect");
    chk({tx_valid, tx_desc.seq}, {1'b1, b}, "desc");
    p_head[1][0].seq <= b + 8'h1;
    wt(0, 300);
    chk(tx_desc.cls, CL_POSTED, "behind");
    p_head <= '0;
    wt(0, 300);
    chk(tx_desc.cls, CL_NONPOSTED, "next");
    rx_free[0][1] <= 1'b1;
    @(posedge clock);
    rx_free <= '0;
    wt(1, 10);
    chk(fc_credits[0][1], 1, "fc");
    wt(1, 4000);
    chk(n >= 2990 && n <= 3010, 1, "refresh");
    end_sim();
  end
endmodule // test_switch_ordering_arbitration_credit
